// *** retimer_pkg.sv ***
// Constants and types of the retimer output select block
package retimer_pkg;

    // Register offsets
    localparam logic [7:0] OFS_OVR = 8'h09;
    localparam logic [7:0] OFS_CLKEN = 8'h0D;
    localparam logic [7:0] OFS_SDET = 8'h14;
    localparam logic [7:0] OFS_DIV = 8'h18;
    localparam logic [7:0] OFS_OSEL = 8'h1E;
    localparam logic [7:0] OFS_PRBS = 8'h30;
    localparam logic [7:0] OFS_STAT = 8'h40;
    localparam logic [7:0] OFS_CHSEL = 8'hFF;

    // Reset values
    localparam logic [7:0] RST_OVR = 8'h00;
    localparam logic [7:0] RST_OSEL = 8'hE0;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Field positions
    localparam int OVR_DIV_BIT = 2;
    localparam int OVR_QCLK_BIT = 4;
    localparam int OVR_OUT_BIT = 5;
    localparam int CLKEN_PRBS_BIT = 5;
    localparam int SDET_ON_BIT = 7;
    localparam int SDET_OFF_BIT = 6;
    localparam int DIV_LSB = 4;
    localparam int OSEL_LSB = 5;
    localparam int OSEL_PRBS_BIT = 4;
    localparam int OSEL_QCLK_BIT = 0;
    localparam int PRBS_LOAD_BIT = 3;
    localparam int PRBS_SEL_LSB = 0;

    // Divider field upper legal code
    localparam logic [2:0] DIV_MAX = 3'h4;

    // Output source codes
    typedef enum logic [2:0] {
        SRC_RAW = 3'h0,
        SRC_RETIMED = 3'h1,
        SRC_ICLK = 3'h2,
        SRC_QCLK = 3'h3,
        SRC_PRBS = 3'h4,
        SRC_OSC = 3'h5,
        SRC_BAD = 3'h6,
        SRC_MUTE = 3'h7
    } src_e;

    // Pattern select codes
    localparam logic [1:0] PAT_P9 = 2'h0;
    localparam logic [1:0] PAT_P31 = 2'h2;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } regReq_s;

endpackage

// *** prbs_gen.sv ***
// Pseudo-random sequence generator, 9-bit or 31-bit
`timescale 1ns/1ps
`default_nettype none
module prbs_gen #(
    parameter int W = 31
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkReset,
    input wire logic run,
    input wire logic [1:0] patSel,
    output logic prbsBit
);
    logic [W-1:0] lfsr_r;
    logic fb;
    logic longSel;

    // Selector 2 picks the long sequence, 0 the short one
    assign longSel = (patSel == retimer_pkg::PAT_P31);
    // x^31+x^28+1 or x^9+x^5+1
    assign fb = longSel ? (lfsr_r[30] ^ lfsr_r[27]) : (lfsr_r[8] ^ lfsr_r[4]);
    assign prbsBit = longSel ? lfsr_r[30] : lfsr_r[8];

    // Clock reset seeds all ones so the sequence never locks up
    always_ff @(posedge clk) begin
        if (rst || clkReset) begin
            lfsr_r <= '1;
        end else if (run) begin
            lfsr_r <= {lfsr_r[W-2:0], fb};
        end
    end
endmodule
`default_nettype wire

// *** retimer_output_select_prbs.sv ***
// Channel output multiplexer, signal detect force, divider override and pattern control
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module retimer_output_select_prbs #(
    parameter int CHAN_IDX = 0
) (
    input wire logic clk,
    input wire logic rst,
    input wire retimer_pkg::regReq_s busReq,
    output logic [7:0] rdData_r,
    input wire logic sigDetPin,
    input wire logic lockPin,
    input wire logic rawData,
    input wire logic retimedData,
    input wire logic vcoIClk,
    input wire logic vcoQClk,
    input wire logic osc10m,
    input wire logic [2:0] autoDivCode,
    output logic serOut_r,
    output logic chanEn_r,
    output logic [2:0] divCode_r,
    output logic [4:0] divRatio_r
);
    localparam int NIN = 7;

    logic [7:0] ovr_r;
    logic [7:0] clkEn_r;
    logic [7:0] sdet_r;
    logic [7:0] div_r;
    logic [7:0] osel_r;
    logic [7:0] prbs_r;
    logic [7:0] chSel_r;
    logic [NIN-1:0] inS1_r;
    logic [NIN-1:0] inS2_r;
    logic sdSync;
    logic lockSync;
    logic rawS;
    logic rtS;
    logic iS;
    logic qS;
    logic oscS;
    logic sdEff;
    logic outOvr;
    logic [2:0] field;
    logic [2:0] divField;
    logic divOvr;
    logic prbsDig;
    logic prbsRun;
    logic prbsBit;
    logic chanHit;
    logic wrHit;
    retimer_pkg::src_e src_nxt;
    retimer_pkg::src_e src_r;
    logic serOut_nxt;
    logic [2:0] divCode_nxt;
    logic [7:0] rd_nxt;

    // Two-flop synchronisers for everything arriving from outside the clock domain
    always_ff @(posedge clk) begin
        if (rst) begin
            inS1_r <= '0;
            inS2_r <= '0;
        end else begin
            inS1_r <= {osc10m, vcoQClk, vcoIClk, retimedData, rawData, lockPin, sigDetPin};
            inS2_r <= inS1_r;
        end
    end

    assign sdSync = inS2_r[0];
    assign lockSync = inS2_r[1];
    assign rawS = inS2_r[2];
    assign rtS = inS2_r[3];
    assign iS = inS2_r[4];
    assign qS = inS2_r[5];
    assign oscS = inS2_r[6];

    // Channel register set only answers while this channel is selected
    assign chanHit = chSel_r[CHAN_IDX];
    assign wrHit = busReq.wr && chanHit;

    // Channel select register, shared by all channels
    always_ff @(posedge clk) begin
        if (rst) begin
            chSel_r <= retimer_pkg::RST_ZERO;
        end else if (busReq.wr && busReq.addr == retimer_pkg::OFS_CHSEL) begin
            chSel_r <= busReq.wdata;
        end
    end

    // Override register; a write of zero drops every override at once
    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_r <= retimer_pkg::RST_OVR;
        end else if (wrHit && busReq.addr == retimer_pkg::OFS_OVR) begin
            ovr_r <= busReq.wdata;
        end
    end

    // Clock enable register, holds the generator clock enable
    always_ff @(posedge clk) begin
        if (rst) begin
            clkEn_r <= retimer_pkg::RST_ZERO;
        end else if (wrHit && busReq.addr == retimer_pkg::OFS_CLKEN) begin
            clkEn_r <= busReq.wdata;
        end
    end

    // Signal detect control register
    always_ff @(posedge clk) begin
        if (rst) begin
            sdet_r <= retimer_pkg::RST_ZERO;
        end else if (wrHit && busReq.addr == retimer_pkg::OFS_SDET) begin
            sdet_r <= busReq.wdata;
        end
    end

    // Divider register
    always_ff @(posedge clk) begin
        if (rst) begin
            div_r <= retimer_pkg::RST_ZERO;
        end else if (wrHit && busReq.addr == retimer_pkg::OFS_DIV) begin
            div_r <= busReq.wdata;
        end
    end

    // Output select register; field starts at mute
    always_ff @(posedge clk) begin
        if (rst) begin
            osel_r <= retimer_pkg::RST_OSEL;
        end else if (wrHit && busReq.addr == retimer_pkg::OFS_OSEL) begin
            osel_r <= busReq.wdata;
        end
    end

    // Generator control register
    always_ff @(posedge clk) begin
        if (rst) begin
            prbs_r <= retimer_pkg::RST_ZERO;
        end else if (wrHit && busReq.addr == retimer_pkg::OFS_PRBS) begin
            prbs_r <= busReq.wdata;
        end
    end

    // Decoded controls
    assign outOvr = ovr_r[retimer_pkg::OVR_OUT_BIT];
    assign divOvr = ovr_r[retimer_pkg::OVR_DIV_BIT];
    assign field = osel_r[retimer_pkg::OSEL_LSB +: 3];
    assign divField = div_r[retimer_pkg::DIV_LSB +: 3];
    assign prbsDig = osel_r[retimer_pkg::OSEL_PRBS_BIT];

    // Force-off wins; force-on alone forces detect; both clear leaves it automatic
    always_comb begin
        unique case ({sdet_r[retimer_pkg::SDET_ON_BIT], sdet_r[retimer_pkg::SDET_OFF_BIT]})
            2'b10: sdEff = 1'b1;
            2'b00: sdEff = sdSync;
            default: sdEff = 1'b0;
        endcase
    end

    // Generator shifts only after digital enable, clock load and clock enable
    assign prbsRun = prbsDig && prbs_r[retimer_pkg::PRBS_LOAD_BIT]
        && clkEn_r[retimer_pkg::CLKEN_PRBS_BIT];

    // Pattern engine; clk stands in for the locked or free-running bit clock
    prbs_gen #(
        .W(31)
    ) u_prbs (
        .clk(clk),
        .rst(rst),
        .clkReset(!prbs_r[retimer_pkg::PRBS_LOAD_BIT]),
        .run(prbsRun),
        .patSel(prbs_r[retimer_pkg::PRBS_SEL_LSB +: 2]),
        .prbsBit(prbsBit)
    );

    // Source choice: powered-down channel mutes, lock wins unless overridden
    always_comb begin
        src_nxt = retimer_pkg::SRC_MUTE;
        if (!sdEff) begin
            src_nxt = retimer_pkg::SRC_MUTE;
        end else if (!outOvr && lockSync) begin
            src_nxt = retimer_pkg::SRC_RETIMED;
        end else begin
            src_nxt = retimer_pkg::src_e'(field);
            // Q-clock needs both enables, else nothing to drive
            if (field == retimer_pkg::SRC_QCLK && !(ovr_r[retimer_pkg::OVR_QCLK_BIT]
                    && osel_r[retimer_pkg::OSEL_QCLK_BIT])) begin
                src_nxt = retimer_pkg::SRC_MUTE;
            end
            // Idle generator would only give a flat line
            if (field == retimer_pkg::SRC_PRBS && !prbsDig) begin
                src_nxt = retimer_pkg::SRC_MUTE;
            end
            // Free oscillator only reachable through the override
            if (field == retimer_pkg::SRC_OSC && !outOvr) begin
                src_nxt = retimer_pkg::SRC_MUTE;
            end
            if (field == retimer_pkg::SRC_BAD) begin
                src_nxt = retimer_pkg::SRC_MUTE;
            end
        end
    end

    // Output multiplexer; free-running raw or retimed inputs just pass noise through
    always_comb begin
        unique case (src_nxt)
            retimer_pkg::SRC_RAW: serOut_nxt = rawS;
            retimer_pkg::SRC_RETIMED: serOut_nxt = rtS;
            retimer_pkg::SRC_ICLK: serOut_nxt = iS;
            retimer_pkg::SRC_QCLK: serOut_nxt = qS;
            retimer_pkg::SRC_PRBS: serOut_nxt = prbsBit;
            retimer_pkg::SRC_OSC: serOut_nxt = oscS;
            retimer_pkg::SRC_BAD: serOut_nxt = 1'b0;
            retimer_pkg::SRC_MUTE: serOut_nxt = 1'b0;
        endcase
    end

    // Registered output stage and channel power state
    always_ff @(posedge clk) begin
        if (rst) begin
            src_r <= retimer_pkg::SRC_MUTE;
            serOut_r <= 1'b0;
            chanEn_r <= 1'b0;
        end else begin
            src_r <= src_nxt;
            serOut_r <= serOut_nxt;
            chanEn_r <= sdEff;
        end
    end

    // Divider: automatic, or overridden; illegal codes keep the last ratio
    always_comb begin
        divCode_nxt = divCode_r;
        if (!divOvr) begin
            if (autoDivCode <= retimer_pkg::DIV_MAX) begin
                divCode_nxt = autoDivCode;
            end
        end else if (divField <= retimer_pkg::DIV_MAX) begin
            divCode_nxt = divField;
        end
    end

    // Applied divider code and ratio
    always_ff @(posedge clk) begin
        if (rst) begin
            divCode_r <= 3'h0;
            divRatio_r <= 5'h01;
        end else begin
            divCode_r <= divCode_nxt;
            divRatio_r <= 5'(5'h01 << divCode_nxt);
        end
    end

    // Read decode; unmapped or other channel reads give zero
    always_comb begin
        rd_nxt = 8'h00;
        if (busReq.addr == retimer_pkg::OFS_CHSEL) begin
            rd_nxt = chSel_r;
        end else if (chanHit) begin
            unique case (busReq.addr)
                retimer_pkg::OFS_OVR: rd_nxt = ovr_r;
                retimer_pkg::OFS_CLKEN: rd_nxt = clkEn_r;
                retimer_pkg::OFS_SDET: rd_nxt = sdet_r;
                retimer_pkg::OFS_DIV: rd_nxt = div_r;
                retimer_pkg::OFS_OSEL: rd_nxt = osel_r;
                retimer_pkg::OFS_PRBS: rd_nxt = prbs_r;
                retimer_pkg::OFS_STAT: rd_nxt = {lockSync, sdEff, src_r, divCode_r};
                default: rd_nxt = 8'h00;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_r <= 8'h00;
        end else if (busReq.rd) begin
            rdData_r <= rd_nxt;
        end else begin
            rdData_r <= 8'h00;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_mute_no_signal: assert property (!sdEff |=> src_r == retimer_pkg::SRC_MUTE && !serOut_r)
        else $error("output not muted without signal detect");

    a_locked_retimed: assert property (sdEff && lockSync && !outOvr
        |=> src_r == retimer_pkg::SRC_RETIMED)
        else $error("locked channel not giving retimed data");

    a_unlocked_field: assert property (sdEff && !lockSync && !outOvr && field == 3'h0
        |=> src_r == retimer_pkg::SRC_RAW)
        else $error("unlocked channel ignored select field");

    a_override_field: assert property (sdEff && lockSync && outOvr && field == 3'h2
        |=> src_r == retimer_pkg::SRC_ICLK)
        else $error("override did not take the select field while locked");

    a_qclk_gate: assert property (src_r == retimer_pkg::SRC_QCLK
        |-> $past(ovr_r[retimer_pkg::OVR_QCLK_BIT] && osel_r[retimer_pkg::OSEL_QCLK_BIT]))
        else $error("Q-clock driven without its enables");

    a_prbs_gate: assert property (src_r == retimer_pkg::SRC_PRBS |-> $past(prbsDig))
        else $error("pattern driven with generator disabled");

    a_osc_gate: assert property (src_r == retimer_pkg::SRC_OSC |-> $past(outOvr))
        else $error("10 MHz clock driven without override");

    a_force_detect: assert property (sdet_r[7:6] == 2'b10 |=> chanEn_r)
        else $error("forced detect did not enable channel");

    a_auto_detect: assert property (sdet_r[7:6] == 2'b00 |=> chanEn_r == $past(sdSync))
        else $error("automatic detect not followed");

    a_div_override: assert property (divOvr && divField <= 3'h4
        |=> divCode_r == $past(divField) && divRatio_r == 5'(5'h01 << $past(divField)))
        else $error("divider override not applied");

    a_div_hold: assert property (divOvr && divField > 3'h4
        |=> divCode_r == $past(divCode_r))
        else $error("illegal divider code changed the ratio");

    a_unlocked_mute: assert property (sdEff && !lockSync && !outOvr && field == 3'h7
        |=> src_r == retimer_pkg::SRC_MUTE && !serOut_r)
        else $error("unlocked channel with default field not muted");

    a_osc_override: assert property (sdEff && outOvr && field == 3'h5
        |=> src_r == retimer_pkg::SRC_OSC)
        else $error("10 MHz clock not reachable under override");

    a_div_auto: assert property (!divOvr && autoDivCode <= 3'h4
        |=> divCode_r == $past(autoDivCode))
        else $error("automatic divider code not applied");

    a_ovr_clear: assert property (wrHit && busReq.addr == retimer_pkg::OFS_OVR
        && busReq.wdata == 8'h00 |=> ovr_r == 8'h00 && !outOvr && !divOvr)
        else $error("zero write left an override set");

    a_read_once: assert property (busReq.rd ##1 !busReq.rd |=> rdData_r == 8'h00)
        else $error("read data stood past its cycle");

endmodule
`default_nettype wire

// *** retimer_src_model.sv ***
// Far-side model: line signal detect, lock and the serial source pins
`timescale 1ns/1ps
`default_nettype none
module retimer_src_model (
    input wire logic clk,
    input wire logic sigOn,
    input wire logic lockOn,
    output logic sigDetPin,
    output logic lockPin,
    output logic [7:0] srcVec
);
    logic [3:0] cnt = 4'h0;

    // Free counter gives srcVec bits 0 to 3 and 5 their own waveforms; bits 4, 6 and 7 stay low
    always @(posedge clk) begin
        cnt <= cnt + 4'h1;
    end

    // Lock only with a signal; raw line stays noisy without one
    always_comb begin
        sigDetPin = sigOn;
        lockPin = sigOn & lockOn;
        srcVec[0] = cnt[0] ^ cnt[2];
        srcVec[1] = cnt[1];
        srcVec[2] = cnt[0];
        srcVec[3] = ~cnt[0];
        srcVec[4] = 1'b0; // Pattern is internal, muted stand-in
        srcVec[5] = cnt[2];
        srcVec[6] = 1'b0;
        srcVec[7] = 1'b0;
    end
endmodule
`default_nettype wire

// *** retimer_output_select_prbs_tb.sv ***
// Self-checking bench of the retimer output select and pattern block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin nMismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module retimer_output_select_prbs_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    retimer_pkg::regReq_s busReq = '0;
    logic sigOn = 1'b0;
    logic lockOn = 1'b0;
    logic [2:0] autoDiv = 3'h0;
    logic [7:0] rdData, srcVec;
    logic sigDetPin, lockPin, serOut, chanEn;
    logic [2:0] divCode;
    logic [4:0] divRatio;
    logic s [0:539];
    int nMismatch = 0;
    int testsRun = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    retimer_output_select_prbs u_dut (.clk(clk), .rst(rst), .busReq(busReq),
        .rdData_r(rdData), .sigDetPin(sigDetPin), .lockPin(lockPin),
        .rawData(srcVec[0]), .retimedData(srcVec[1]), .vcoIClk(srcVec[2]),
        .vcoQClk(srcVec[3]), .osc10m(srcVec[5]), .autoDivCode(autoDiv),
        .serOut_r(serOut), .chanEn_r(chanEn), .divCode_r(divCode), .divRatio_r(divRatio));

    retimer_src_model u_src (.clk(clk), .sigOn(sigOn), .lockOn(lockOn),
        .sigDetPin(sigDetPin), .lockPin(lockPin), .srcVec(srcVec));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One-cycle strobes, idle cycle between so no signal is driven twice per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= {a, d, 2'b10};
        @(posedge clk);
        busReq <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk);
        busReq <= {a, 8'h00, 2'b01};
        @(posedge clk);
        busReq <= '0;
        #1;
        `CHK("rdData", ex, rdData)
    endtask

    task automatic set_line(input logic sg, input logic lk);
        @(posedge clk);
        sigOn <= sg;
        lockOn <= lk;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Output must track the source three edges late; k=7 means muted
    task automatic chk_out(input int k);
        logic [3:0] h;
        logic ok;
        h = 4'h0;
        ok = 1'b1;
        settle();
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            h = {h[2:0], srcVec[k]};
            if (i > 2 && serOut !== h[3]) ok = 1'b0;
        end
        `CHK("serOut", 1'b1, ok)
    endtask

    // Period 511 separates the short sequence from the long one
    task automatic collect(output logic per, output int ones);
        per = 1'b1;
        ones = 0;
        for (int i = 0; i < 540; i++) begin
            @(negedge clk);
            s[i] = serOut;
            if (serOut === 1'b1) ones++;
        end
        for (int i = 0; i < 29; i++) if (s[i] !== s[i + 511]) per = 1'b0;
    endtask

    task automatic t_reset();
        rd_chk(8'h1E, 8'h00);
        wr(8'hFF, 8'h01);
        rd_chk(8'hFF, 8'h01);
        rd_chk(8'h09, 8'h00);
        rd_chk(8'h1E, 8'hE0);
        rd_chk(8'h55, 8'h00);
        `CHK("divRatio", 5'h01, divRatio)
        $display("test reset done");
    endtask

    task automatic t_default();
        settle();
        `CHK("chanEn", 1'b0, chanEn)
        chk_out(7);
        set_line(1'b1, 1'b0);
        chk_out(7);
        set_line(1'b1, 1'b1);
        chk_out(1);
        wr(8'h1E, 8'h00);
        set_line(1'b1, 1'b0);
        chk_out(0);
        set_line(1'b1, 1'b1);
        chk_out(1);
        rd_chk(8'h40, 8'hC8);
        $display("test default done");
    endtask

    task automatic t_override();
        int expK [8] = '{0, 1, 2, 7, 7, 7, 7, 7};
        expK[5] = 5;
        wr(8'h09, 8'h20);
        for (int c = 0; c < 8; c++) begin
            wr(8'h1E, {3'(c), 5'h00});
            chk_out(expK[c]);
        end
        wr(8'h09, 8'h30);
        wr(8'h1E, 8'h61);
        chk_out(3);
        wr(8'h1E, 8'h00);
        wr(8'h09, 8'h00);
        chk_out(1);
        rd_chk(8'h09, 8'h00);
        $display("test override done");
    endtask

    task automatic t_force();
        wr(8'h14, 8'h40);
        settle();
        `CHK("chanEn", 1'b0, chanEn)
        wr(8'h14, 8'h00);
        settle();
        `CHK("chanEn", 1'b1, chanEn)
        set_line(1'b0, 1'b0);
        wr(8'h14, 8'h80);
        settle();
        `CHK("chanEn", 1'b1, chanEn)
        wr(8'h09, 8'h20);
        chk_out(0);
        wr(8'h1E, 8'hA0);
        chk_out(5);
        wr(8'h14, 8'h00);
        settle();
        `CHK("chanEn", 1'b0, chanEn)
        chk_out(7);
        wr(8'h09, 8'h00);
        $display("test force done");
    endtask

    task automatic t_div();
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            autoDiv <= 3'(k);
            settle();
            `CHK("divRatio", 5'h01 << k, divRatio)
        end
        @(posedge clk);
        autoDiv <= 3'h6;
        settle();
        `CHK("divRatio", 5'h10, divRatio)
        wr(8'h09, 8'h04);
        for (int k = 0; k < 5; k++) begin
            wr(8'h18, {1'b0, 3'(k), 4'h0});
            settle();
            `CHK("divCode", 3'(k), divCode)
            `CHK("divRatio", 5'h01 << k, divRatio)
        end
        wr(8'h18, 8'h10);
        wr(8'h18, 8'h50);
        settle();
        `CHK("divRatio", 5'h02, divRatio)
        wr(8'h09, 8'h00);
        $display("test divider done");
    endtask

    task automatic t_prbs();
        logic per;
        int ones;
        set_line(1'b1, 1'b1);
        wr(8'h09, 8'h20);
        wr(8'h1E, 8'h80);
        chk_out(4);
        wr(8'h1E, 8'h90);
        wr(8'h30, 8'h00);
        wr(8'h30, 8'h00);
        wr(8'h30, 8'h08);
        wr(8'h0D, 8'h20);
        settle();
        collect(per, ones);
        `CHK("periodic", 1'b1, per)
        `CHK("toggling", 1'b1, ones > 0 && ones < 540)
        wr(8'h30, 8'h00);
        wr(8'h30, 8'h02);
        wr(8'h30, 8'h0A);
        settle();
        collect(per, ones);
        `CHK("periodic", 1'b0, per)
        `CHK("toggling", 1'b1, ones > 0 && ones < 540)
        $display("test pattern done");
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_default();
        t_override();
        t_force();
        t_div();
        t_prbs();
        tally_and_finish();
    end

    // Hang guard
    initial begin
        repeat (40000) @(posedge clk);
        nMismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
